//--- logic/mrt_pkg.sv
package mrt_pkg;
  // Tag of one register half
  typedef enum logic [1:0] {
    TAG_ANY,
    TAG_SINGLE,
    TAG_DOUBLE,
    TAG_INT
  } mrt_tag_t;

  // Instruction class
  typedef enum logic [2:0] {
    CLS_SINGLE,
    CLS_DOUBLE,
    CLS_INT,
    CLS_LOAD,
    CLS_STORE
  } mrt_cls_t;

  // Special operation kinds
  typedef enum logic [2:0] {
    OP_PLAIN,
    OP_SELF_XOR,
    OP_SCALAR_MOVE,
    OP_FULL_MOVE,
    OP_TO_GPR,
    OP_FROM_GPR,
    OP_FP_EXTRACT
  } mrt_op_t;

  localparam int NUM_REGS = 16;
  localparam int REG_IDX_W = 4;
  localparam int MISMATCH_CYCLES = 2;
  localparam int XFILE_CYCLES = 3;
  localparam int EXTRACT_CYCLES = 2;
  localparam int PEN_W = 4;
  localparam mrt_tag_t RESET_TAG = TAG_ANY;
endpackage

//--- logic/mrt_tag_mem.sv
`timescale 1ns/1ps
// ----------------------------------------
// Tag store, two halves per register
// ----------------------------------------
module mrt_tag_mem
  import mrt_pkg::*;
#(
  parameter int DEPTH = NUM_REGS,
  parameter int AW = REG_IDX_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AW-1:0] rd_a_idx,
  input wire logic [AW-1:0] rd_b_idx,
  input wire logic [AW-1:0] rd_d_idx,
  output mrt_tag_t rd_a_lo,
  output mrt_tag_t rd_a_hi,
  output mrt_tag_t rd_b_lo,
  output mrt_tag_t rd_b_hi,
  output mrt_tag_t rd_d_lo,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic wr_lo_en,
  input wire logic wr_hi_en,
  input mrt_tag_t wr_lo,
  input mrt_tag_t wr_hi
);
  mrt_tag_t lo_r [DEPTH];
  mrt_tag_t hi_r [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk) begin
        if (rst) begin
          lo_r[g] <= RESET_TAG; // [RULE19]
          hi_r[g] <= RESET_TAG;
        end else if (wr_en && wr_idx == AW'(g)) begin
          if (wr_lo_en) lo_r[g] <= wr_lo; // [RULE8]
          if (wr_hi_en) hi_r[g] <= wr_hi;
        end
      end
    end
  endgenerate

  // Combinational read; pipeline registers the result
  assign rd_a_lo = lo_r[rd_a_idx];
  assign rd_a_hi = hi_r[rd_a_idx];
  assign rd_b_lo = lo_r[rd_b_idx];
  assign rd_b_hi = hi_r[rd_b_idx];
  assign rd_d_lo = lo_r[rd_d_idx];
endmodule // mrt_tag_mem

//--- logic/mrt_tracker.sv
`timescale 1ns/1ps
// Function
// RULE1: Each register half holds a single, double or integer tag.
// RULE2: Instructions are classed single, double, integer, load or store.
// RULE3: Source tag differing from consumer class adds latency, result unchanged.
// RULE4: Store class accepts any source tag with no penalty.
// RULE5: Implicit memory second operand is not tag checked.
// RULE6: Integer 128 or 64 bit load leaves a universally accepted tag.
// RULE7: Producer sets destination tag to its own class.
// RULE8: Halves tracked apart; scalar double conversion writes low half only.
// RULE9: Low-half double load sets low tag, keeps high tag.
// RULE10: Half mismatch harmless for scalar ops, penalised for vector sources.
// RULE11: Vector-only logicals check both halves of both sources.
// RULE12: Self-xor zeroing sets both halves to the idiom's class.
// RULE13: Scalar single move penalised when destination prior tag not single.
// RULE14: Full single move penalised if either source half not single.
// RULE15: Cross register file moves take longer than in-file moves.
// RULE16: Penalties only on early revision; parameter disables all of them. EARLY_REV drops only the mismatch cost; cross-file and extract costs stay.
// RULE17: Float word-extract or doubleword_move to general_register costs extra.
// RULE18: Penalty is a parameterised cycle count; tags alter only timing.
// RULE19: Reset puts every half in the integer-load accepted state.
module mrt_tracker
  import mrt_pkg::*;
#(
  parameter bit EARLY_REV = 1'b1,
  parameter int MISMATCH_PEN = MISMATCH_CYCLES,
  parameter int XFILE_PEN = XFILE_CYCLES,
  parameter int EXTRACT_PEN = EXTRACT_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic ISSUE_VALID,
  input mrt_cls_t ISSUE_CLASS,
  input mrt_tag_t ISSUE_LOAD_TYPE,
  input mrt_op_t ISSUE_OP,
  input wire logic ISSUE_VECTOR,
  input wire logic ISSUE_LOW_ONLY,
  input wire logic ISSUE_SRC_A_VALID,
  input wire logic [REG_IDX_W-1:0] ISSUE_SRC_A,
  input wire logic ISSUE_SRC_B_VALID,
  input wire logic ISSUE_SRC_B_MEM,
  input wire logic [REG_IDX_W-1:0] ISSUE_SRC_B,
  input wire logic ISSUE_DST_VALID,
  input wire logic [REG_IDX_W-1:0] ISSUE_DST,
  input wire logic ISSUE_INT_LOAD_WIDE,
  output logic PEN_VALID,
  output logic [PEN_W-1:0] PEN_CYCLES,
  output logic PEN_MISMATCH,
  output logic PEN_XFILE
);

  // ----------------------------------------
  // Tag store
  // ----------------------------------------
  mrt_tag_t a_lo, a_hi, b_lo, b_hi, d_lo;
  logic wr_en, wr_lo_en, wr_hi_en;
  mrt_tag_t wr_lo, wr_hi;

  mrt_tag_mem #(.DEPTH(NUM_REGS), .AW(REG_IDX_W)) u_mem (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .rd_a_idx(ISSUE_SRC_A),
    .rd_b_idx(ISSUE_SRC_B),
    .rd_d_idx(ISSUE_DST),
    .rd_a_lo(a_lo),
    .rd_a_hi(a_hi),
    .rd_b_lo(b_lo),
    .rd_b_hi(b_hi),
    .rd_d_lo(d_lo),
    .wr_en(wr_en),
    .wr_idx(ISSUE_DST),
    .wr_lo_en(wr_lo_en),
    .wr_hi_en(wr_hi_en),
    .wr_lo(wr_lo),
    .wr_hi(wr_hi)
  );

  // ----------------------------------------
  // Tag check
  // ----------------------------------------
  function automatic logic tag_bad(input mrt_tag_t t, input mrt_tag_t want);
    tag_bad = (t != TAG_ANY) && (t != want);
  endfunction

  mrt_tag_t want;
  logic cons, chk_a, chk_b, full_src, mism, xfile, extract;

  always_comb begin
    want = TAG_INT;
    case (ISSUE_CLASS) // [RULE2]
      CLS_SINGLE: want = TAG_SINGLE;
      CLS_DOUBLE: want = TAG_DOUBLE;
      CLS_INT: want = TAG_INT;
      default: want = TAG_ANY;
    endcase
    // Store and load consume nothing checked
    cons = ISSUE_CLASS != CLS_STORE && ISSUE_CLASS != CLS_LOAD
      && ISSUE_OP != OP_SELF_XOR; // [RULE4]
    chk_a = ISSUE_SRC_A_VALID && cons;
    // Second source checked on its own, unless it comes from memory
    chk_b = ISSUE_SRC_B_VALID && !ISSUE_SRC_B_MEM && cons; // [RULE5]
    // Vector sources (logicals included) check both halves
    full_src = ISSUE_VECTOR || ISSUE_OP == OP_FULL_MOVE; // [RULE10] [RULE11]
    mism = 1'b0;
    if (chk_a) begin
      mism = tag_bad(a_lo, want); // [RULE3]
      if (full_src) mism = mism || tag_bad(a_hi, want); // [RULE14]
    end
    if (chk_b) begin
      mism = mism || tag_bad(b_lo, want);
      if (full_src) mism = mism || tag_bad(b_hi, want); // [RULE11]
    end
    if (ISSUE_OP == OP_SCALAR_MOVE && ISSUE_CLASS == CLS_SINGLE && ISSUE_DST_VALID) begin
      mism = mism || tag_bad(d_lo, TAG_SINGLE); // [RULE13]
    end
    xfile = ISSUE_OP == OP_TO_GPR || ISSUE_OP == OP_FROM_GPR
      || ISSUE_OP == OP_FP_EXTRACT; // [RULE15]
    extract = ISSUE_OP == OP_FP_EXTRACT; // [RULE17]
  end

  // ----------------------------------------
  // Tag update
  // ----------------------------------------
  mrt_tag_t prod;

  always_comb begin
    prod = want; // [RULE7]
    if (ISSUE_CLASS == CLS_LOAD) begin
      prod = ISSUE_LOAD_TYPE;
      if (ISSUE_LOAD_TYPE == TAG_INT && ISSUE_INT_LOAD_WIDE) prod = TAG_ANY; // [RULE6]
    end
    wr_en = ISSUE_VALID && ISSUE_DST_VALID && ISSUE_CLASS != CLS_STORE
      && ISSUE_OP != OP_TO_GPR && ISSUE_OP != OP_FP_EXTRACT; // [RULE1]
    wr_lo_en = 1'b1;
    // Self-xor always writes both halves
    wr_hi_en = !ISSUE_LOW_ONLY || ISSUE_OP == OP_SELF_XOR; // [RULE8] [RULE9] [RULE12]
    wr_lo = prod;
    wr_hi = prod;
  end

  // ----------------------------------------
  // Penalty output
  // ----------------------------------------
  logic pen_valid_r, pen_valid_nxt;
  logic pen_mism_r, pen_mism_nxt;
  logic pen_xfile_r, pen_xfile_nxt;
  logic [PEN_W-1:0] pen_cyc_r, pen_cyc_nxt;

  always_comb begin
    pen_valid_nxt = ISSUE_VALID;
    pen_mism_nxt = ISSUE_VALID && EARLY_REV && mism; // [RULE16]
    pen_xfile_nxt = ISSUE_VALID && xfile;
    pen_cyc_nxt = '0;
    if (pen_mism_nxt) pen_cyc_nxt = pen_cyc_nxt + PEN_W'(MISMATCH_PEN); // [RULE18]
    if (pen_xfile_nxt) pen_cyc_nxt = pen_cyc_nxt + PEN_W'(XFILE_PEN);
    if (ISSUE_VALID && extract) pen_cyc_nxt = pen_cyc_nxt + PEN_W'(EXTRACT_PEN); // [RULE17]
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pen_valid_r <= 1'b0;
      pen_mism_r <= 1'b0;
      pen_xfile_r <= 1'b0;
      pen_cyc_r <= '0;
    end else begin
      pen_valid_r <= pen_valid_nxt;
      pen_mism_r <= pen_mism_nxt;
      pen_xfile_r <= pen_xfile_nxt;
      pen_cyc_r <= pen_cyc_nxt;
    end
  end

  assign PEN_VALID = pen_valid_r;
  assign PEN_MISMATCH = pen_mism_r;
  assign PEN_XFILE = pen_xfile_r;
  assign PEN_CYCLES = pen_cyc_r;
endmodule // mrt_tracker

//--- testbench/mrt_tracker_asserts.sv
`timescale 1ns/1ps
module mrt_tracker_asserts
  import mrt_pkg::*;
#(
  parameter bit EARLY_REV = 1'b1
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic ISSUE_VALID,
  input mrt_cls_t ISSUE_CLASS,
  input mrt_op_t ISSUE_OP,
  input wire logic ISSUE_SRC_A_VALID,
  input wire logic ISSUE_SRC_B_MEM,
  input wire logic PEN_VALID,
  input wire logic [PEN_W-1:0] PEN_CYCLES,
  input wire logic PEN_MISMATCH,
  input wire logic PEN_XFILE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  a_pen_follows: assert property (ISSUE_VALID |=> PEN_VALID)
    else $error("no answer");
  a_pen_quiet: assert property (!ISSUE_VALID |=> !PEN_VALID && PEN_CYCLES == '0)
    else $error("answer without issue");
  a_ldst_free: assert property (
    ISSUE_VALID && ISSUE_CLASS inside {CLS_LOAD, CLS_STORE} |=> !PEN_MISMATCH)
    else $error("load or store penalised");
  a_mem_free: assert property (
    ISSUE_VALID && ISSUE_SRC_B_MEM && !ISSUE_SRC_A_VALID && ISSUE_OP == OP_PLAIN
    |=> !PEN_MISMATCH) else $error("memory operand penalised");
  a_xor_free: assert property (ISSUE_VALID && ISSUE_OP == OP_SELF_XOR |=> !PEN_MISMATCH)
    else $error("zeroing penalised");
  a_xfile_kind: assert property (
    ISSUE_VALID |=> PEN_XFILE == ($past(ISSUE_OP) inside {OP_TO_GPR, OP_FROM_GPR, OP_FP_EXTRACT}))
    else $error("cross-file flag wrong");
  a_late_rev: assert property (PEN_MISMATCH |-> EARLY_REV && PEN_VALID)
    else $error("mismatch on late part");
  a_flag_cost: assert property (PEN_MISMATCH || PEN_XFILE |-> PEN_CYCLES != '0)
    else $error("flag with no cycles");
endmodule // mrt_tracker_asserts

bind mrt_tracker mrt_tracker_asserts #(.EARLY_REV(EARLY_REV)) chk_u (.*);

//--- testbench/mrt_issue_model.sv
`timescale 1ns/1ps
module mrt_issue_model
  import mrt_pkg::*;
(
  input wire logic SYS_CLK,
  output logic ISSUE_VALID,
  output mrt_cls_t ISSUE_CLASS,
  output mrt_tag_t ISSUE_LOAD_TYPE,
  output mrt_op_t ISSUE_OP,
  output logic ISSUE_VECTOR,
  output logic ISSUE_LOW_ONLY,
  output logic ISSUE_SRC_A_VALID,
  output logic [REG_IDX_W-1:0] ISSUE_SRC_A,
  output logic ISSUE_SRC_B_VALID,
  output logic ISSUE_SRC_B_MEM,
  output logic [REG_IDX_W-1:0] ISSUE_SRC_B,
  output logic ISSUE_DST_VALID,
  output logic [REG_IDX_W-1:0] ISSUE_DST,
  output logic ISSUE_INT_LOAD_WIDE
);
  initial begin
    {ISSUE_VALID, ISSUE_VECTOR, ISSUE_LOW_ONLY, ISSUE_SRC_B_MEM, ISSUE_INT_LOAD_WIDE} = '0;
    {ISSUE_SRC_A_VALID, ISSUE_SRC_A, ISSUE_SRC_B_VALID, ISSUE_SRC_B} = '0;
    {ISSUE_DST_VALID, ISSUE_DST} = '0;
    ISSUE_CLASS = CLS_INT;
    ISSUE_LOAD_TYPE = TAG_INT;
    ISSUE_OP = OP_PLAIN;
  end
  // One instruction per call; indices scrambled while idle
  task automatic iss(input mrt_cls_t c, mrt_tag_t t, mrt_op_t o, logic [3:0] f,
      logic [4:0] a, logic [4:0] b, logic [4:0] d);
    @(posedge SYS_CLK);
    ISSUE_VALID <= 1'b1;
    ISSUE_CLASS <= c;
    ISSUE_LOAD_TYPE <= t;
    ISSUE_OP <= o;
    {ISSUE_VECTOR, ISSUE_LOW_ONLY, ISSUE_SRC_B_MEM, ISSUE_INT_LOAD_WIDE} <= f;
    {ISSUE_SRC_A_VALID, ISSUE_SRC_A, ISSUE_SRC_B_VALID, ISSUE_SRC_B} <= {a, b};
    {ISSUE_DST_VALID, ISSUE_DST} <= d;
    @(posedge SYS_CLK);
    ISSUE_VALID <= 1'b0;
    {ISSUE_SRC_A, ISSUE_SRC_B, ISSUE_DST} <= ~{a[3:0], b[3:0], d[3:0]};
  endtask
endmodule // mrt_issue_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import mrt_pkg::*;
  localparam mrt_cls_t cs = CLS_SINGLE, cd = CLS_DOUBLE, ci = CLS_INT;
  localparam int mm = MISMATCH_CYCLES, xf = XFILE_CYCLES;
  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic ISSUE_VALID, ISSUE_VECTOR, ISSUE_LOW_ONLY, ISSUE_SRC_A_VALID, ISSUE_SRC_B_VALID;
  logic ISSUE_SRC_B_MEM, ISSUE_DST_VALID, ISSUE_INT_LOAD_WIDE, PEN_VALID, PEN_MISMATCH, PEN_XFILE;
  logic [REG_IDX_W-1:0] ISSUE_SRC_A, ISSUE_SRC_B, ISSUE_DST;
  logic [PEN_W-1:0] PEN_CYCLES;
  mrt_cls_t ISSUE_CLASS;
  mrt_tag_t ISSUE_LOAD_TYPE;
  mrt_op_t ISSUE_OP;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  logic late_valid, late_mism, late_xfile;
  logic [PEN_W-1:0] late_cyc;
  mrt_tracker dut_u (.*);
  // Later revision: mismatch penalties switched off
  mrt_tracker #(.EARLY_REV(1'b0)) dut_late_u (
    .SYS_CLK(SYS_CLK),
    .SYS_RST(SYS_RST),
    .ISSUE_VALID(ISSUE_VALID),
    .ISSUE_CLASS(ISSUE_CLASS),
    .ISSUE_LOAD_TYPE(ISSUE_LOAD_TYPE),
    .ISSUE_OP(ISSUE_OP),
    .ISSUE_VECTOR(ISSUE_VECTOR),
    .ISSUE_LOW_ONLY(ISSUE_LOW_ONLY),
    .ISSUE_SRC_A_VALID(ISSUE_SRC_A_VALID),
    .ISSUE_SRC_A(ISSUE_SRC_A),
    .ISSUE_SRC_B_VALID(ISSUE_SRC_B_VALID),
    .ISSUE_SRC_B_MEM(ISSUE_SRC_B_MEM),
    .ISSUE_SRC_B(ISSUE_SRC_B),
    .ISSUE_DST_VALID(ISSUE_DST_VALID),
    .ISSUE_DST(ISSUE_DST),
    .ISSUE_INT_LOAD_WIDE(ISSUE_INT_LOAD_WIDE),
    .PEN_VALID(late_valid),
    .PEN_CYCLES(late_cyc),
    .PEN_MISMATCH(late_mism),
    .PEN_XFILE(late_xfile)
  );
  mrt_issue_model model_u (.*);
  always #2 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      final_report();
    end
  end
  task automatic cmp(input logic [6:0] got, input logic [6:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input mrt_cls_t c, logic [3:0] f, logic [4:0] a, logic [4:0] b,
      logic [4:0] d, logic [1:0] mx, int n, mrt_op_t o = OP_PLAIN, mrt_tag_t t = TAG_INT);
    int late_n;
    model_u.iss(c, t, o, f, a, b, d);
    #1;
    late_n = mx[1] ? n - mm : n;
    cmp({PEN_VALID, PEN_MISMATCH, PEN_XFILE, PEN_CYCLES}, {1'b1, mx, PEN_W'(n)});
    cmp({late_valid, late_mism, late_xfile, late_cyc}, {2'b10, mx[0], PEN_W'(late_n)});
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_produce();
    run(ci, 4'h8, 5'h11, 5'h12, '0, 2'b00, 0);
    run(cd, 4'h8, '0, '0, 5'h14, 2'b00, 0);
    run(ci, 4'h0, 5'h14, '0, '0, 2'b10, mm);
    run(CLS_STORE, 4'h8, 5'h14, '0, '0, 2'b00, 0);
    run(ci, 4'h0, '0, 5'h14, '0, 2'b10, mm);
    run(ci, 4'h2, '0, 5'h14, '0, 2'b00, 0);
    run(CLS_LOAD, 4'h1, '0, '0, 5'h14, 2'b00, 0);
    run(cd, 4'h8, 5'h14, '0, '0, 2'b00, 0);
    $display("t_produce done");
  endtask
  task automatic t_halves();
    run(cs, 4'h8, '0, '0, 5'h15, 2'b00, 0);
    run(cd, 4'h4, '0, '0, 5'h15, 2'b00, 0);
    run(cd, 4'h0, 5'h15, '0, '0, 2'b00, 0);
    run(cd, 4'h8, 5'h15, '0, '0, 2'b10, mm);
    run(cs, 4'h0, '0, '0, 5'h16, 2'b00, 0, OP_SELF_XOR);
    run(CLS_LOAD, 4'h4, '0, '0, 5'h16, 2'b00, 0, OP_PLAIN, TAG_DOUBLE);
    run(cd, 4'h8, 5'h16, '0, '0, 2'b10, mm);
    run(ci, 4'h8, 5'h14, 5'h16, '0, 2'b10, mm);
    $display("t_halves done");
  endtask
  task automatic t_reset();
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    run(cd, 4'h8, 5'h15, 5'h16, '0, 2'b00, 0);
    $display("t_reset done");
  endtask
  task automatic t_moves();
    run(cd, 4'h0, '0, '0, 5'h19, 2'b00, 0, OP_SELF_XOR);
    run(cs, 4'h4, 5'h11, '0, 5'h19, 2'b10, mm, OP_SCALAR_MOVE);
    run(cs, 4'h0, 5'h19, '0, 5'h1a, 2'b10, mm, OP_FULL_MOVE);
    run(cd, 4'h0, '0, '0, 5'h1b, 2'b01, xf, OP_FROM_GPR);
    run(ci, 4'h8, 5'h1b, '0, '0, 2'b10, mm);
    run(ci, 4'h0, 5'h11, '0, '0, 2'b01, xf, OP_TO_GPR);
    run(cs, 4'h0, 5'h1a, '0, '0, 2'b01, xf + EXTRACT_CYCLES, OP_FP_EXTRACT);
    $display("t_moves done");
  endtask
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    t_produce();
    t_halves();
    t_reset();
    t_moves();
    final_report();
  end
endmodule // tb
